// ### fpc_fetch_ctrl.sv
`timescale 1ns/10ps
module fpc_fetch_ctrl #(
  parameter logic [15:0] INT_VECTOR  = 16'h0008,
  parameter int          STACK_DEPTH = 16
) (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic [15:0]        prog_data_in,
  input  wire fpc_pkg::fpc_exec_t exec_in,
  input  wire logic               int_req_in,
  output logic [15:0]             prog_addr_out,
  output logic [15:0]             instruction_holding_register_out,
  output logic                    forced_nop_out,
  output fpc_pkg::fpc_phase_t     phase_out,
  output logic [7:0]              rd_data_out,
  output logic [15:0]             program_counter_out,
  output logic [7:0]              program_counter_high_latch_out,
  output logic                    int_ack_out
);

  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  if (STACK_DEPTH < 2) begin : g_bad_stack
    $error("fpc_fetch_ctrl STACK_DEPTH must be at least 2");
  end

  // -----------------------------------------------------------------
  // Phase generator and return stack
  // -----------------------------------------------------------------
  fpc_pkg::fpc_phase_t phase;
  logic                push;
  logic                pop;
  logic [15:0]         push_data;
  logic [15:0]         stack_top;

  fpc_phase_gen u_phase (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .phase_out (phase)
  );

  fpc_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .push_in      (push),
    .pop_in       (pop),
    .push_data_in (push_data),
    .top_out      (stack_top)
  );

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  logic [15:0] pc;
  logic [7:0]  latch;
  logic        hold;
  logic        flush;
  logic [15:0] fetch_word;
  logic [15:0] ir;
  logic        ir_nop;
  logic [15:0] prog_addr;
  logic [7:0]  rd_data;
  logic        int_ack;

  logic [15:0] next_pc;
  logic [7:0]  next_latch;
  logic        next_hold;
  logic        next_flush;
  logic [15:0] next_fetch_word;
  logic [15:0] next_ir;
  logic        next_ir_nop;
  logic [15:0] next_prog_addr;
  logic [7:0]  next_rd_data;
  logic        next_int_ack;

  logic        live;
  logic        any_return;
  logic        pc_change;
  logic        take_int;
  logic [15:0] inc_pc;

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    next_pc         = pc;
    next_latch      = latch;
    next_hold       = hold;
    next_flush      = flush;
    next_fetch_word = fetch_word;
    next_ir         = ir;
    next_ir_nop     = ir_nop;
    next_prog_addr  = prog_addr;
    next_rd_data    = rd_data;
    next_int_ack    = 1'b0;
    push            = 1'b0;
    pop             = 1'b0;
    push_data       = pc;

    // A forced idle word must not act, whatever the decoder says of it.
    live       = !ir_nop;
    any_return = exec_in.return_op | exec_in.table_return_op
               | exec_in.interrupt_return_op;
    pc_change  = live & (exec_in.jump_op | exec_in.call_op
               | exec_in.long_call_op | any_return
               | exec_in.low_write | exec_in.low_rmw);
    // An interrupt waits for a cycle that neither branches nor skips,
    // so the address it saves is always one that must still execute.
    take_int   = int_req_in & !pc_change & !(live & exec_in.skip);
    inc_pc     = hold ? pc : pc + fpc_pkg::PC_STEP;

    // Phase one: retire the fetched word into the holding register and
    // start the next fetch, so fetch and execute overlap.
    if (phase.phase_one) begin
      next_pc        = inc_pc;
      next_prog_addr = inc_pc;
      next_hold      = 1'b0;
      next_flush     = 1'b0;
      if (flush) begin
        next_ir     = fpc_pkg::NOP_WORD;
        next_ir_nop = 1'b1;
      end else begin
        next_ir     = fetch_word;
        next_ir_nop = 1'b0;
      end
    end

    // Phase two: operand reads of the mapped bytes.
    if (phase.phase_two && live) begin
      if (exec_in.low_read || exec_in.low_rmw) begin
        next_rd_data = pc[7:0];
      end else if (exec_in.latch_read) begin
        next_rd_data = latch;
      end
      if (exec_in.low_read && !exec_in.low_rmw) begin
        next_latch = pc[15:8];
      end
    end

    // Phase four: capture the fetch, then apply destination writes and
    // flow changes, which override the increment made in phase one.
    if (phase.phase_four) begin
      next_fetch_word = prog_data_in;
      if (live) begin
        if (exec_in.return_op) begin
          next_pc = stack_top;
          pop     = 1'b1;
        end else if (exec_in.table_return_op
                     || exec_in.interrupt_return_op) begin
          next_pc = stack_top;
          pop     = 1'b1;
        end else if (exec_in.call_op || exec_in.jump_op) begin
          next_pc    = {pc[15:fpc_pkg::JMP_W],
                        ir[fpc_pkg::JMP_W-1:0]};
          next_latch = {pc[15:fpc_pkg::JMP_W],
                        ir[fpc_pkg::JMP_W-1:fpc_pkg::BYTE_W]};
          push       = exec_in.call_op;
        end else if (exec_in.long_call_op) begin
          next_pc = {latch, ir[fpc_pkg::BYTE_W-1:0]};
          push    = 1'b1;
        end else if (exec_in.low_write || exec_in.low_rmw) begin
          next_pc = {latch, exec_in.wr_data};
        end else if (exec_in.latch_write) begin
          next_latch = exec_in.wr_data;
        end
        if (exec_in.skip && !pc_change) begin
          next_flush = 1'b1;
        end
      end
      if (pc_change) begin
        next_flush = 1'b1;
        next_hold  = 1'b1;
      end else if (take_int) begin
        // The vector is forced onto the counter; the latch is untouched.
        next_pc      = INT_VECTOR;
        push         = 1'b1;
        next_flush   = 1'b1;
        next_hold    = 1'b1;
        next_int_ack = 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  // After reset the first phase one fetches the reset address without an
  // increment, and the garbage captured before it is flushed.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc         <= fpc_pkg::RESET_PC;
      latch      <= fpc_pkg::RESET_LATCH;
      hold       <= 1'b1;
      flush      <= 1'b1;
      fetch_word <= fpc_pkg::NOP_WORD;
      ir         <= fpc_pkg::NOP_WORD;
      ir_nop     <= 1'b1;
      prog_addr  <= fpc_pkg::RESET_PC;
      rd_data    <= fpc_pkg::RESET_DATA;
      int_ack    <= 1'b0;
    end else begin
      pc         <= next_pc;
      latch      <= next_latch;
      hold       <= next_hold;
      flush      <= next_flush;
      fetch_word <= next_fetch_word;
      ir         <= next_ir;
      ir_nop     <= next_ir_nop;
      prog_addr  <= next_prog_addr;
      rd_data    <= next_rd_data;
      int_ack    <= next_int_ack;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prog_addr_out                    = prog_addr;
  assign instruction_holding_register_out = ir;
  assign forced_nop_out                   = ir_nop;
  assign phase_out                        = phase;
  assign rd_data_out                      = rd_data;
  assign program_counter_out              = pc;
  assign program_counter_high_latch_out   = latch;
  assign int_ack_out                      = int_ack;

endmodule : fpc_fetch_ctrl

// ### fpc_pkg.sv
// Function
// - Divide oscillator by four into phases.
// - Advance counter phase one, capture phase four.
// - Fetch next word while executing current.
// - Hold word from phase one, execute two-four.
// - Read operands phase two, write phase four.
// - Flow changes flush prefetch as forced idle.
// - Counter sixteen bits, low byte mapped.
// - High byte reached only through latch.
// - Increment unless branch, interrupt, low write.
// - Skipped word runs as forced idle.
// - Long call: low from opcode, high latch.
// - Low byte read copies high into latch.
// - Low byte write loads high from latch.
// - Modify-write loads high, leaves latch alone.
// - Jump or call: thirteen bits, latch page.
// - Latch unchanged by returns, vector, modify-write.
package fpc_pkg;

  localparam int          PC_W        = 16;
  localparam int          BYTE_W      = 8;
  localparam int          OP_W        = 16;
  localparam int          JMP_W       = 13;
  localparam int          PAGE_LSB    = 5;
  localparam int          PHASE_DIV   = 4;
  localparam logic [15:0] NOP_WORD    = 16'h0000;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [7:0]  RESET_LATCH = 8'h00;
  localparam logic [7:0]  RESET_DATA  = 8'h00;
  localparam logic [15:0] PC_STEP     = 16'h0001;

  // -----------------------------------------------------------------
  // Phase sequencer states and flags
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } fpc_phase_state_t;

  typedef struct packed {
    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;
  } fpc_phase_t;

  // -----------------------------------------------------------------
  // Decoded class of the word in the instruction holding register
  // -----------------------------------------------------------------
  typedef struct packed {
    logic             jump_op;
    logic             call_op;
    logic             long_call_op;
    logic             return_op;
    logic             table_return_op;
    logic             interrupt_return_op;
    logic             skip;
    logic             low_read;
    logic             low_write;
    logic             low_rmw;
    logic             latch_read;
    logic             latch_write;
    logic [7:0]       wr_data;
  } fpc_exec_t;

endpackage : fpc_pkg

// ### fpc_phase_gen.sv
`timescale 1ns/10ps
module fpc_phase_gen (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  output fpc_pkg::fpc_phase_t phase_out
);

  fpc_pkg::fpc_phase_state_t state;
  fpc_pkg::fpc_phase_state_t next_state;
  fpc_pkg::fpc_phase_t       next_phase;

  // -----------------------------------------------------------------
  // Divide by four, one phase flag per oscillator cycle
  // -----------------------------------------------------------------
  always_comb begin
    next_phase = '0;
    case (state)
      fpc_pkg::PH_ONE: begin
        next_state            = fpc_pkg::PH_TWO;
        next_phase.phase_two  = 1'b1;
      end
      fpc_pkg::PH_TWO: begin
        next_state             = fpc_pkg::PH_THREE;
        next_phase.phase_three = 1'b1;
      end
      fpc_pkg::PH_THREE: begin
        next_state            = fpc_pkg::PH_FOUR;
        next_phase.phase_four = 1'b1;
      end
      default: begin
        next_state           = fpc_pkg::PH_ONE;
        next_phase.phase_one = 1'b1;
      end
    endcase
  end

  // Reset sits in phase four so the first cycle after release is phase one.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= fpc_pkg::PH_FOUR;
      phase_out <= 4'h1;
    end else begin
      state     <= next_state;
      phase_out <= next_phase;
    end
  end

endmodule : fpc_phase_gen

// ### fpc_stack.sv
`timescale 1ns/10ps
module fpc_stack #(
  parameter int DEPTH = 16
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  input  wire logic [15:0] push_data_in,
  output logic      [15:0] top_out
);

  localparam int PTR_W = $clog2(DEPTH);

  // -----------------------------------------------------------------
  // Circular return stack
  // -----------------------------------------------------------------
  // Overflow wraps and overwrites the oldest entry, as the core gives
  // software no stack-full trap of its own.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fpc_stack DEPTH must be a power of two of at least 2");
  end

  logic [15:0]      mem [DEPTH];
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic [PTR_W-1:0] wr_idx;

  always_comb begin
    wr_idx   = ptr + PTR_W'(1);
    next_ptr = ptr;
    if (push_in) begin
      next_ptr = wr_idx;
    end else if (pop_in) begin
      next_ptr = ptr - PTR_W'(1);
    end
  end

  assign top_out = mem[ptr];

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr <= '0;
    end else begin
      ptr <= next_ptr;
    end
  end

  // Storage carries no reset; an empty stack reads whatever was last left.
  always_ff @(posedge clk_in) begin
    if (push_in) begin
      mem[wr_idx] <= push_data_in;
    end
  end

endmodule : fpc_stack

// ### fpc_fetch_ctrl_properties.sv
`timescale 1ns/10ps
module fpc_fetch_ctrl_properties #(
  parameter logic [15:0] INT_VECTOR  = 16'h0008,
  parameter int          STACK_DEPTH = 16
) (
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire fpc_pkg::fpc_exec_t  exec_in,
  input wire logic                int_req_in,
  input wire logic [15:0]         instruction_holding_register_out,
  input wire logic                forced_nop_out,
  input wire fpc_pkg::fpc_phase_t phase_out,
  input wire logic [15:0]         program_counter_out,
  input wire logic [7:0]          program_counter_high_latch_out,
  input wire logic                int_ack_out
);
  // ---------------------------------------------------------------
  // Pipeline and counter checks
  // ---------------------------------------------------------------
  wire [15:0] pc  = program_counter_out;
  wire [15:0] ir  = instruction_holding_register_out;
  wire [7:0]  lat = program_counter_high_latch_out;
  wire [2:0]  pg  = pc[15:13];
  wire [12:0] tgt = ir[12:0];
  wire [4:0]  pgl = ir[12:8];
  wire [7:0]  lo  = ir[7:0];
  wire [7:0]  hi  = pc[15:8];
  wire [7:0]  wd  = exec_in.wr_data;
  wire        p4  = phase_out.phase_four && !forced_nop_out;
  wire        flow = exec_in.jump_op || exec_in.call_op || exec_in.long_call_op
                  || exec_in.return_op || exec_in.table_return_op || exec_in.skip
                  || exec_in.interrupt_return_op || exec_in.low_write || exec_in.low_rmw;
  // A forced idle word may carry any decode, so it never counts as a flow change.
  wire        quiet = phase_out.phase_four && (forced_nop_out || !flow);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  phase_order_a: assert property (phase_out.phase_one |=> phase_out.phase_two ##1
    phase_out.phase_three ##1 phase_out.phase_four ##1 phase_out.phase_one) else $error("phase order");
  ir_hold_a: assert property (!phase_out.phase_one |=> $stable(ir))
    else $error("holding register moved");
  // A live low byte read copies the high byte into the latch at the phase-two edge.
  latch_hold_a: assert property (!phase_out.phase_four && !(phase_out.phase_two
    && exec_in.low_read && !exec_in.low_rmw && !forced_nop_out) |=> $stable(lat))
    else $error("latch moved");
  flush_nop_a: assert property (p4 && flow |=> ##1 forced_nop_out && ir == fpc_pkg::NOP_WORD)
    else $error("no flush");
  jump_load_a: assert property (p4 && (exec_in.jump_op || exec_in.call_op) |=>
    pc == {$past(pg), $past(tgt)} && lat == {$past(pg), $past(pgl)}) else $error("jump target");
  long_call_a: assert property (p4 && exec_in.long_call_op |=>
    pc == {$past(lat), $past(lo)} && $stable(lat)) else $error("long call target");
  low_write_a: assert property (p4 && (exec_in.low_write || exec_in.low_rmw) |=>
    pc == {$past(lat), $past(wd)} && $stable(lat)) else $error("low byte write");
  low_read_a: assert property (p4 && exec_in.low_read && !flow |=> lat == $past(hi))
    else $error("low byte read latch");
  // The phase four held in reset is not a real one; the first fetch after it has no increment.
  pc_step_a: assert property (quiet && !int_req_in && $past(rst_n_in) |=> ##1
    pc == $past(pc, 2) + 16'h0001) else $error("no increment");
  int_take_a: assert property (quiet && int_req_in |=> int_ack_out && pc == INT_VECTOR
    ##1 !int_ack_out) else $error("interrupt response");

  call_c: cover property (p4 && exec_in.call_op);
  irq_c: cover property (quiet && int_req_in);
  rmw_c: cover property (p4 && exec_in.low_rmw);
endmodule : fpc_fetch_ctrl_properties

bind fpc_fetch_ctrl fpc_fetch_ctrl_properties #(
  .INT_VECTOR(INT_VECTOR), .STACK_DEPTH(STACK_DEPTH)
) u_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .exec_in(exec_in), .int_req_in(int_req_in),
  .instruction_holding_register_out(instruction_holding_register_out),
  .forced_nop_out(forced_nop_out), .phase_out(phase_out), .int_ack_out(int_ack_out),
  .program_counter_out(program_counter_out),
  .program_counter_high_latch_out(program_counter_high_latch_out)
);

// ### fpc_prog_mem.sv
`timescale 1ns/10ps
module fpc_prog_mem #(
  parameter int SETTLE = 1
) (
  input  wire logic        clk_in,
  input  wire logic [15:0] addr_in,
  output logic      [15:0] data_out
);
  // ---------------------------------------------------------------
  // Program memory
  // ---------------------------------------------------------------
  // The word is only good once the address has stood still for a while;
  // before that the inverse shows, so an early sample cannot pass.
  logic [15:0] last_addr = '0;
  logic [1:0]  age       = '0;
  logic [15:0] word;
  assign word = {~addr_in[7:0], addr_in[15:8] + 8'h3c};
  always_ff @(posedge clk_in) begin
    last_addr <= addr_in;
    if (addr_in != last_addr)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end
  assign data_out = (addr_in == last_addr && int'(age) >= SETTLE) ? word : ~word;
endmodule : fpc_prog_mem

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ---------------------------------------------------------------
  // Design, memory and reference model
  // ---------------------------------------------------------------
  localparam logic [15:0] INT_VEC = 16'h0120;
  logic                clk_in     = 1'b0;
  logic                rst_n_in   = 1'b0;
  logic                int_req_in = 1'b0;
  fpc_pkg::fpc_exec_t  exec_in    = '0;
  fpc_pkg::fpc_phase_t phase;
  logic [15:0]         pdata, paddr, ir, pc, m_pc, m_fw, m_ir;
  logic [15:0]         stk[$];
  logic [7:0]          rd, lat, m_lat;
  logic                fnop, ack;
  bit                  m_hold, m_flush, m_nop;
  int                  n_errors = 0;
  int                  compares = 0;
  int                  dk[14] = '{0, 1, 0, 0, 6, 0, 2, 0, 4, 0, 11, 3, 0, 10};
  bit                  di[14] = '{0, 1, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

  always #20 clk_in = ~clk_in;

  fpc_prog_mem u_mem (.clk_in(clk_in), .addr_in(paddr), .data_out(pdata));
  fpc_fetch_ctrl #(.INT_VECTOR(INT_VEC)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .prog_data_in(pdata), .exec_in(exec_in),
    .int_req_in(int_req_in), .prog_addr_out(paddr), .instruction_holding_register_out(ir),
    .forced_nop_out(fnop), .phase_out(phase), .rd_data_out(rd), .program_counter_out(pc),
    .program_counter_high_latch_out(lat), .int_ack_out(ack));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  task automatic do_reset;
    @(posedge clk_in);
    rst_n_in   <= 1'b0;
    exec_in    <= '0;
    int_req_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk("phase", 16'(phase), 16'h0008);
    m_pc    = '0;
    m_lat   = '0;
    m_fw    = '0;
    m_hold  = 1'b1;
    m_flush = 1'b1;
    stk.delete();
  endtask : do_reset

  // One instruction cycle: k selects the decoded class, irq the request level.
  task automatic step(input int k, input bit irq, input logic [7:0] wd);
    fpc_pkg::fpc_exec_t e;
    logic [15:0]        a;
    bit                 take;
    e = '0;
    e.wr_data = wd;
    // The stack wraps, so the model never lets it overflow or underflow.
    if (stk.size() > 13 && (k == 2 || k == 3))
      k = 0;
    if (stk.size() > 13)
      irq = 1'b0;
    if (stk.size() == 0 && k >= 4 && k <= 6)
      k = 0;
    case (k)
      1: e.jump_op = 1'b1;
      2: e.call_op = 1'b1;
      3: e.long_call_op = 1'b1;
      4: e.return_op = 1'b1;
      5: e.table_return_op = 1'b1;
      6: e.interrupt_return_op = 1'b1;
      7: e.skip = 1'b1;
      8: e.low_read = 1'b1;
      9: e.low_write = 1'b1;
      10: e.low_rmw = 1'b1;
      11: e.latch_write = 1'b1;
      12: e.latch_read = 1'b1;
      default: ;
    endcase
    @(posedge clk_in);
    exec_in    <= e;
    int_req_in <= irq;
    if (!m_hold)
      m_pc = m_pc + 16'h0001;
    m_ir    = m_flush ? fpc_pkg::NOP_WORD : m_fw;
    m_nop   = m_flush;
    m_hold  = 1'b0;
    m_flush = 1'b0;
    a       = m_pc;
    #1;
    chk("ir", ir, m_ir);
    chk("nop", 16'(fnop), 16'(m_nop));
    chk("addr", paddr, a);
    @(posedge clk_in);
    #1;
    if (!m_nop && (k == 8 || k == 10))
      chk("rd low", 16'(rd), 16'(a[7:0]));
    if (!m_nop && k == 12)
      chk("rd latch", 16'(rd), 16'(m_lat));
    repeat (2) @(posedge clk_in);
    m_fw = {~a[7:0], a[15:8] + 8'h3c};
    take = irq && (m_nop || k == 0 || k == 8 || k > 10);
    if (!m_nop) begin
      case (k)
        1, 2: begin
          if (k == 2)
            stk.push_back(a);
          m_lat = {a[15:13], m_ir[12:8]};
          m_pc  = {a[15:13], m_ir[12:0]};
        end
        3: begin
          stk.push_back(a);
          m_pc = {m_lat, m_ir[7:0]};
        end
        4, 5, 6: m_pc = stk.pop_back();
        8: m_lat = a[15:8];
        9, 10: m_pc = {m_lat, wd};
        11: m_lat = wd;
        default: ;
      endcase
      m_flush = k >= 1 && k <= 10 && k != 8;
      m_hold  = m_flush && k != 7;
    end
    if (take) begin
      stk.push_back(a);
      m_pc    = INT_VEC;
      m_hold  = 1'b1;
      m_flush = 1'b1;
    end
    #1;
    chk("pc", pc, m_pc);
    chk("latch", 16'(lat), 16'(m_lat));
    chk("ack", 16'(ack), 16'(take));
  endtask : step

  task automatic run(input int n);
    repeat (n) step(int'($urandom_range(12, 0)), $urandom_range(3, 0) == 0, 8'($urandom));
  endtask : run

  initial begin
    void'($urandom(51));
    do_reset();
    foreach (dk[i])
      step(dk[i], di[i], 8'($urandom));
    run(300);
    do_reset();
    run(100);
    test_done();
  end

  initial begin
    #(40 * 4000);
    n_errors++;
    test_done();
  end
endmodule : tb_top
